// *** rtl/ucg_consts.vh ***
`ifndef UCG_CONSTS_VH
`define UCG_CONSTS_VH
// register byte addresses (word aligned)
`define UCG_ADDR_CTRL1 12'h000
`define UCG_ADDR_CTRL2 12'h004
`define UCG_ADDR_FLAGS 12'h008
`define UCG_ADDR_BAUD 12'h00c
`define UCG_ADDR_DATA 12'h010
`define UCG_ADDR_IRQ_STAT 12'h014
`define UCG_ADDR_IRQ_MASK 12'h018
`define UCG_ADDR_POWER 12'h01c
// primary control field positions
`define UCG_C1_TXE 7
`define UCG_C1_RXE 6
`define UCG_C1_STOP 5
`define UCG_C1_EVEN 4
`define UCG_C1_PAR 3
`define UCG_C1_IRSEL 2
`define UCG_C1_BSRC 1
// secondary control field positions
`define UCG_C2_RTSEL_LO 3
`define UCG_C2_NOISE_LO 1
`define UCG_C2_RSTOP 0
// flag field positions
`define UCG_SR_PFAIL 7
`define UCG_SR_FFAIL 6
`define UCG_SR_OFAIL 5
`define UCG_SR_RACT 3
`define UCG_SR_RFULL 2
`define UCG_SR_TACT 1
`define UCG_SR_TFULL 0
// interrupt status bits
`define UCG_IRQ_TXDONE 0
`define UCG_IRQ_TXEMPTY 1
// power control field positions
`define UCG_PW_MODE_LO 0
`define UCG_PW_DRIVE 2
// low-power mode codes
`define UCG_PM_RUN 2'h0
`define UCG_PM_IDLE 2'h1
`define UCG_PM_SLEEP 2'h2
`define UCG_PM_STOP 2'h3
// reset values
`define UCG_RST_BYTE 8'h00
`define UCG_RST_BAUD 8'h00
// infrared pulse: fraction of a bit time is 3/16
`define UCG_IR_PULSE_TICKS 3
`define UCG_TICKS_PER_BIT 16
`endif

// *** rtl/ucg_uart.v ***
// Notes on behaviour
// - writes to a locked control field are dropped; old value kept
// - tx stop length writable only when tx enable and tx active are zero
// - parity fields writable only when both enables and active flags are zero
// - infrared select writable only when tx enable and tx active are zero
// - baud source and sample count writable only when all four are zero
// - noise filter and rx stop length writable only when rx side idle
// - low-power entry halts port, clears enables and flags, keeps settings
// - idle or sleep: pin high if infrared off, low if on
// - stop: same levels if drive setting is one, else pin released
// - frame starts with one low start bit then eight data bits
// - parity bit only when parity on; even field picks even or odd
// - one or two high stop bits per tx stop length
// - infrared select emits short high pulses for zero bits
// - tx active is one only while a frame is sent
// - two rx stop bits: first one is not checked for framing
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "ucg_consts.vh"
module ucg_uart #(
  parameter DATA_BITS = 8
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // receive status from the receiver core
  input wire i_rx_active,
  input wire i_rx_done,
  input wire [7:0] i_rx_data,
  input wire i_rx_parity_fail,
  input wire i_rx_frame_fail,
  // serial output pin
  output reg o_serial_out_pin,
  output reg o_serial_out_pin_oe,
  // receive settings towards the receiver core
  output wire o_rx_enable,
  output wire o_rx_stop_two,
  output wire o_rx_check_first_stop,
  output wire [1:0] o_rx_noise_sel,
  output wire [2:0] o_rx_rtsel,
  output wire o_baud_src,
  // interrupt
  output wire o_irq
);

  reg [7:0] ctrl1;
  reg [7:0] ctrl2;
  reg [7:0] baud;
  reg [7:0] tx_hold;
  reg [7:0] rx_hold;
  reg tx_full;
  reg rx_full;
  reg parity_fail;
  reg frame_fail;
  reg overrun_fail;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg [2:0] power;
  reg [7:0] tick_cnt;
  reg tick;
  reg [3:0] sub_cnt;
  reg [10:0] shift;
  reg [3:0] bits_left;
  reg tx_line;
  reg [2:0] state;
  reg tx_done_ev;
  reg [31:0] rdata;

  localparam ST_IDLE = 3'b001;
  localparam ST_SEND = 3'b010;
  localparam ST_LAST = 3'b100;

  wire wr_en = i_psel & i_penable & i_pwrite;
  wire rd_en = i_psel & ~i_pwrite;
  wire tx_act = (state != ST_IDLE);
  wire tx_busy_side = ctrl1[`UCG_C1_TXE] | tx_act;
  wire rx_busy_side = ctrl1[`UCG_C1_RXE] | i_rx_active;
  wire [1:0] pmode = power[`UCG_PW_MODE_LO+1:`UCG_PW_MODE_LO];
  wire low_power = (pmode != `UCG_PM_RUN);
  wire wr_ctrl1 = wr_en & (i_paddr == `UCG_ADDR_CTRL1);
  wire wr_ctrl2 = wr_en & (i_paddr == `UCG_ADDR_CTRL2);
  wire wr_data = wr_en & (i_paddr == `UCG_ADDR_DATA);
  wire wr_power = wr_en & (i_paddr == `UCG_ADDR_POWER);
  wire [7:0] wb = i_pwdata[7:0];
  wire tx_empty_ev = tx_done_ev;

  // apb: zero wait state, error only on address above 12'h01f
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & (i_paddr[11:5] != 7'h00);
  assign o_prdata = rdata;
  assign o_irq = |(irq_stat & irq_mask);

  assign o_rx_enable = ctrl1[`UCG_C1_RXE];
  assign o_rx_stop_two = ctrl2[`UCG_C2_RSTOP];
  assign o_rx_check_first_stop = ~ctrl2[`UCG_C2_RSTOP];
  assign o_rx_noise_sel = ctrl2[`UCG_C2_NOISE_LO+1:`UCG_C2_NOISE_LO];
  assign o_rx_rtsel = ctrl2[`UCG_C2_RTSEL_LO+2:`UCG_C2_RTSEL_LO];
  assign o_baud_src = ctrl1[`UCG_C1_BSRC];

  // read mux; unused bits read zero
  always @*
  begin
    rdata = 32'h0000_0000;
    if (rd_en)
    begin
      case (i_paddr)
        `UCG_ADDR_CTRL1: rdata[7:0] = {ctrl1[7:1], 1'b0};
        `UCG_ADDR_CTRL2: rdata[5:0] = ctrl2[5:0];
        `UCG_ADDR_FLAGS: rdata[7:0] = {parity_fail, frame_fail, overrun_fail, 1'b0,
                                       i_rx_active & ~low_power, rx_full, tx_act, tx_full};
        `UCG_ADDR_BAUD: rdata[7:0] = baud;
        `UCG_ADDR_DATA: rdata[7:0] = rx_hold;
        `UCG_ADDR_IRQ_STAT: rdata[1:0] = irq_stat;
        `UCG_ADDR_IRQ_MASK: rdata[1:0] = irq_mask;
        `UCG_ADDR_POWER: rdata[2:0] = power;
        default: rdata = 32'h0000_0000;
      endcase
    end
  end

  // control registers with field locks
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl1 <= `UCG_RST_BYTE;
      ctrl2 <= `UCG_RST_BYTE;
      baud <= `UCG_RST_BAUD;
      power <= 3'h0;
      irq_mask <= 2'h0;
    end
    else
    begin
      if (wr_power)
        power <= wb[2:0];
      if (wr_en & (i_paddr == `UCG_ADDR_IRQ_MASK))
        irq_mask <= wb[1:0];
      // baud divider not guarded; software clears enables first
      if (wr_en & (i_paddr == `UCG_ADDR_BAUD))
        baud <= wb;
      // settings stay writable in low power; the enables are forced off below
      if (wr_ctrl1)
      begin
        ctrl1[`UCG_C1_TXE] <= wb[`UCG_C1_TXE];
        ctrl1[`UCG_C1_RXE] <= wb[`UCG_C1_RXE];
        if (!tx_busy_side)
          ctrl1[`UCG_C1_STOP] <= wb[`UCG_C1_STOP];
        if (!tx_busy_side && !rx_busy_side)
        begin
          ctrl1[`UCG_C1_EVEN] <= wb[`UCG_C1_EVEN];
          ctrl1[`UCG_C1_PAR] <= wb[`UCG_C1_PAR];
        end
        if (!tx_busy_side)
          ctrl1[`UCG_C1_IRSEL] <= wb[`UCG_C1_IRSEL];
        if (!tx_busy_side && !rx_busy_side)
          ctrl1[`UCG_C1_BSRC] <= wb[`UCG_C1_BSRC];
      end
      // clear both enables, last assignment wins over a write
      if (low_power)
      begin
        ctrl1[`UCG_C1_TXE] <= 1'b0;
        ctrl1[`UCG_C1_RXE] <= 1'b0;
      end
      if (wr_ctrl2)
      begin
        if (!tx_busy_side && !rx_busy_side)
          ctrl2[`UCG_C2_RTSEL_LO+2:`UCG_C2_RTSEL_LO] <= wb[`UCG_C2_RTSEL_LO+2:`UCG_C2_RTSEL_LO];
        if (!rx_busy_side)
        begin
          ctrl2[`UCG_C2_NOISE_LO+1:`UCG_C2_NOISE_LO] <= wb[`UCG_C2_NOISE_LO+1:`UCG_C2_NOISE_LO];
          ctrl2[`UCG_C2_RSTOP] <= wb[`UCG_C2_RSTOP];
        end
      end
    end
  end

  // status flags; hardware set wins over clear
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rx_full <= 1'b0;
      rx_hold <= `UCG_RST_BYTE;
      parity_fail <= 1'b0;
      frame_fail <= 1'b0;
      overrun_fail <= 1'b0;
      irq_stat <= 2'h0;
    end
    else if (low_power)
    begin
      rx_full <= 1'b0;
      parity_fail <= 1'b0;
      frame_fail <= 1'b0;
      overrun_fail <= 1'b0;
      irq_stat <= 2'h0;
    end
    else
    begin
      if (i_rx_done && ctrl1[`UCG_C1_RXE])
      begin
        rx_hold <= i_rx_data;
        rx_full <= 1'b1;
        overrun_fail <= overrun_fail | rx_full;
        parity_fail <= i_rx_parity_fail;
        frame_fail <= i_rx_frame_fail;
      end
      else if (rd_en & i_penable & (i_paddr == `UCG_ADDR_DATA))
      begin
        rx_full <= 1'b0;
        overrun_fail <= 1'b0;
      end
      // write one to clear, event set wins
      irq_stat <= (irq_stat & ~({2{wr_en & (i_paddr == `UCG_ADDR_IRQ_STAT)}} & wb[1:0]))
                  | {tx_empty_ev, tx_done_ev};
    end
  end

  // baud tick: divider+1 clocks per sixteenth of a bit
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (tick_cnt == baud);
      tick_cnt <= (tick_cnt == baud) ? 8'h00 : tick_cnt + 8'h01;
    end
  end

  // transmitter: frame shift register, lsb first
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= ST_IDLE;
      shift <= 11'h7ff;
      bits_left <= 4'h0;
      sub_cnt <= 4'h0;
      tx_hold <= `UCG_RST_BYTE;
      tx_full <= 1'b0;
      tx_done_ev <= 1'b0;
    end
    else
    begin
      tx_done_ev <= 1'b0;
      if (wr_data && !low_power)
      begin
        tx_hold <= wb;
        tx_full <= 1'b1;
      end
      case (state)
        ST_IDLE:
        begin
          sub_cnt <= 4'h0;
          if (tx_full && ctrl1[`UCG_C1_TXE] && tick && !low_power)
          begin
            // lsb first, parity after bit seven
            if (ctrl1[`UCG_C1_PAR])
            begin
              shift <= {1'b1, ctrl1[`UCG_C1_EVEN] ? ^tx_hold : ~^tx_hold, tx_hold, 1'b0};
              // count includes the first stop bit so tx active covers it
              bits_left <= 4'd11;
            end
            else
            begin
              shift <= {2'b11, tx_hold, 1'b0};
              bits_left <= 4'd10;
            end
            tx_full <= 1'b0;
            state <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (tick)
          begin
            sub_cnt <= sub_cnt + 4'h1;
            if (sub_cnt == 4'hf)
            begin
              shift <= {1'b1, shift[10:1]};
              bits_left <= bits_left - 4'h1;
              if (bits_left == 4'h1)
                state <= ctrl1[`UCG_C1_STOP] ? ST_LAST : ST_IDLE;
              if (bits_left == 4'h1 && !ctrl1[`UCG_C1_STOP])
                tx_done_ev <= 1'b1;
            end
          end
        end
        ST_LAST:
        begin
          if (tick)
          begin
            sub_cnt <= sub_cnt + 4'h1;
            if (sub_cnt == 4'hf)
            begin
              state <= ST_IDLE;
              tx_done_ev <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (low_power)
      begin
        state <= ST_IDLE;
        tx_full <= 1'b0;
        shift <= 11'h7ff;
      end
    end
  end

  // line level: first stop bit high via shift fill; idle and second stop bit forced high outside ST_SEND
  always @*
  begin
    tx_line = (state == ST_SEND) ? shift[0] : 1'b1;
  end

  // pin driver
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_serial_out_pin <= 1'b1;
      o_serial_out_pin_oe <= 1'b1;
    end
    else
    begin
      o_serial_out_pin_oe <= 1'b1;
      if (pmode == `UCG_PM_IDLE || pmode == `UCG_PM_SLEEP)
        o_serial_out_pin <= ~ctrl1[`UCG_C1_IRSEL];
      else if (pmode == `UCG_PM_STOP)
      begin
        o_serial_out_pin <= ~ctrl1[`UCG_C1_IRSEL];
        o_serial_out_pin_oe <= power[`UCG_PW_DRIVE];
      end
      else if (ctrl1[`UCG_C1_IRSEL])
        // infrared: short high pulse for a zero bit
        o_serial_out_pin <= ~tx_line && (sub_cnt < `UCG_IR_PULSE_TICKS);
      else
        o_serial_out_pin <= tx_line;
    end
  end

endmodule // ucg_uart
`default_nettype wire

// *** tb/ucg_uart_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ucg_consts.vh"
module ucg_uart_checker #(
  parameter DATA_BITS = 8
) (
  // clock, reset and bus writes
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  // receive side
  input wire logic i_rx_active,
  input wire logic o_rx_enable,
  input wire logic o_rx_stop_two,
  input wire logic o_rx_check_first_stop,
  input wire logic [1:0] o_rx_noise_sel,
  input wire logic [2:0] o_rx_rtsel,
  input wire logic o_baud_src,
  // serial pin
  input wire logic o_serial_out_pin,
  input wire logic o_serial_out_pin_oe
);
  logic [2:0] pw;
  logic ir, txen;
  wire wr = i_psel && i_penable && i_pwrite;
  wire lp = pw[1:0] != `UCG_PM_RUN;
  wire drv = pw[1:0] != `UCG_PM_STOP || pw[`UCG_PW_DRIVE];
  wire pin = o_serial_out_pin;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // shadow of power mode and ir select, rebuilt from bus writes
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pw <= 3'h0;
      ir <= 1'b0;
      txen <= 1'b0;
    end
    else if (wr && i_paddr == `UCG_ADDR_POWER)
    begin
      pw <= i_pwdata[2:0];
      txen <= 1'b0;
    end
    else if (wr && i_paddr == `UCG_ADDR_CTRL1)
    begin
      txen <= i_pwdata[`UCG_C1_TXE] && !lp;
      // bench only moves ir with tx fully idle
      if (!txen)
        ir <= i_pwdata[`UCG_C1_IRSEL];
    end
  end
  rx_chk_a:
    assert property (o_rx_check_first_stop == !o_rx_stop_two) else $error("first stop check wrong");
  rx_lock_a:
    assert property ($changed({o_rx_noise_sel, o_rx_stop_two}) |-> !$past(o_rx_enable) && !$past(i_rx_active))
      else $error("rx framing changed while busy");
  clk_lock_a:
    assert property ($changed({o_rx_rtsel, o_baud_src}) |-> !$past(o_rx_enable) && !$past(i_rx_active))
      else $error("clocking changed while busy");
  lp_rxoff_a:
    assert property (lp && $stable(pw) |-> !o_rx_enable) else $error("rx enable kept in low power");
  lp_pin_a:
    assert property (lp && drv && $stable(pw) && $stable(ir) |-> o_serial_out_pin_oe && pin == !ir)
      else $error("pin level wrong in low power");
  stop_hiz_a:
    assert property (lp && !drv && $stable(pw) |-> !o_serial_out_pin_oe) else $error("pin driven in stop");
  start_low_a:
    assert property (!ir && !lp && $fell(pin) |-> (!pin || lp) [*8]) else $error("low bit too short");
  ir_pulse_a:
    assert property (ir && !lp && $rose(pin) |-> pin [*3] ##1 !pin) else $error("ir pulse wrong");
  c_ir: cover property (ir && $rose(pin));
  c_hiz: cover property (lp && !o_serial_out_pin_oe);
  c_frame: cover property (!ir && $fell(pin));
endmodule // ucg_uart_checker
bind ucg_uart ucg_uart_checker #(.DATA_BITS(DATA_BITS)) u_chk (.*);
`default_nettype wire

// *** tb/ucg_peer.sv ***
`timescale 1ns/1ns
`default_nettype none
module ucg_peer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // line and frame length in bits
  input wire logic i_line,
  input wire logic [3:0] i_nbits,
  // decoded frame, bit 0 is the start bit
  output logic [11:0] o_frame,
  output logic o_got
);
  logic [3:0] n, cnt;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      n <= 4'h0;
      cnt <= 4'h0;
      o_got <= 1'b0;
      o_frame <= 12'hfff;
    end
    else
    begin
      o_got <= 1'b0;
      if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (n == 4'h0 && !i_line)
      begin
        n <= 4'h1;
        cnt <= 4'h7;
        o_frame <= 12'hfff;
      end
      else if (n != 4'h0)
      begin
        o_frame[n - 4'h1] <= i_line;
        cnt <= 4'hf;
        n <= (n == i_nbits) ? 4'h0 : n + 4'h1;
        o_got <= n == i_nbits;
      end
    end
  end
endmodule // ucg_peer
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ucg_consts.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb;
  logic clk, rst_n, psel, pen, pwr, rx_act, pready, slverr, pin, oe, irq, got;
  logic [11:0] addr, frame;
  logic [31:0] wdat, prdata, q;
  logic [3:0] nb;
  int n_fail, num_checks;
  // released pin shows the inverse of its last level
  wire line = oe ? pin : ~pin;
  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ucg_uart i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prdata), .o_pready(pready), .o_pslverr(slverr),
    .i_rx_active(rx_act), .i_rx_done(1'b0), .i_rx_data(8'h00), .i_rx_parity_fail(1'b0),
    .i_rx_frame_fail(1'b0), .o_serial_out_pin(pin), .o_serial_out_pin_oe(oe), .o_rx_enable(),
    .o_rx_stop_two(), .o_rx_check_first_stop(), .o_rx_noise_sel(), .o_rx_rtsel(), .o_baud_src(), .o_irq(irq));
  ucg_peer u_peer (.i_clk(clk), .i_rst_n(rst_n), .i_line(line), .i_nbits(nb), .o_frame(frame), .o_got(got));
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one bus transfer, held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      n_fail++;
      final_report;
    end
    q = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q[7:0], e)
  endtask
  task automatic t_lock;
    rc(12'h100, 8'h00);
    wr(`UCG_ADDR_CTRL1, 8'h80);
    wr(`UCG_ADDR_CTRL1, 8'hbe);
    rc(`UCG_ADDR_CTRL1, 8'h80);
    wr(`UCG_ADDR_CTRL1, 8'h40);
    wr(`UCG_ADDR_CTRL1, 8'h7a);
    rc(`UCG_ADDR_CTRL1, 8'h60);
    wr(`UCG_ADDR_CTRL2, 8'h3f);
    rc(`UCG_ADDR_CTRL2, 8'h00);
    wr(`UCG_ADDR_CTRL1, 8'h00);
    rx_act <= 1'b1;
    wr(`UCG_ADDR_CTRL2, 8'h3f);
    rc(`UCG_ADDR_CTRL2, 8'h00);
    rx_act <= 1'b0;
    wr(`UCG_ADDR_CTRL2, 8'h3f);
    rc(`UCG_ADDR_CTRL2, 8'h3f);
    wr(`UCG_ADDR_CTRL2, 8'h00);
    $display("t_lock done");
  endtask
  // every parity and stop setting, frame decoded by the peer
  task automatic t_frame;
    logic [7:0] cf [4] = '{8'h00, 8'h08, 8'h30, 8'h38};
    logic [7:0] dv [4] = '{8'hc5, 8'h01, 8'h80, 8'h6e};
    logic [11:0] e;
    int k;
    for (int i = 0; i < 4; i++)
    begin
      e = {3'b111, dv[i], 1'b0};
      if (cf[i][3])
        e[9] = cf[i][4] ? ^dv[i] : ~^dv[i];
      nb <= 4'd10 + {3'b0, cf[i][3]} + {3'b0, cf[i][5]};
      wr(`UCG_ADDR_CTRL1, cf[i]);
      wr(`UCG_ADDR_CTRL1, cf[i] | 8'h80);
      wr(`UCG_ADDR_DATA, dv[i]);
      apb(1'b0, `UCG_ADDR_FLAGS, 32'h0);
      `CHK(q[1], 1'b1)
      k = 0;
      while (got !== 1'b1 && k < 400)
      begin
        @(posedge clk);
        k++;
      end
      if (k >= 400)
      begin
        n_fail++;
        final_report;
      end
      `CHK(frame, e)
      repeat (16) @(posedge clk);
      apb(1'b0, `UCG_ADDR_FLAGS, 32'h0);
      `CHK(q[1], 1'b0)
      wr(`UCG_ADDR_CTRL1, cf[i]);
    end
    $display("t_frame done");
  endtask
  task automatic t_irq;
    rc(`UCG_ADDR_IRQ_STAT, 8'h03);
    `CHK(irq, 1'b0)
    wr(`UCG_ADDR_IRQ_STAT, 8'h01);
    rc(`UCG_ADDR_IRQ_STAT, 8'h02);
    wr(`UCG_ADDR_IRQ_MASK, 8'h03);
    @(posedge clk);
    `CHK(irq, 1'b1)
    wr(`UCG_ADDR_IRQ_STAT, 8'h02);
    @(posedge clk);
    `CHK(irq, 1'b0)
    $display("t_irq done");
  endtask
  // nine zero bits, three high cycles each
  task automatic t_ir;
    int k;
    wr(`UCG_ADDR_CTRL1, 8'h04);
    wr(`UCG_ADDR_CTRL1, 8'h84);
    wr(`UCG_ADDR_CTRL1, 8'h80);
    rc(`UCG_ADDR_CTRL1, 8'h84);
    wr(`UCG_ADDR_DATA, 8'h00);
    k = 0;
    repeat (200)
    begin
      @(posedge clk);
      k += pin;
    end
    `CHK(k, 27)
    wr(`UCG_ADDR_CTRL1, 8'h04);
    wr(`UCG_ADDR_CTRL1, 8'h00);
    $display("t_ir done");
  endtask
  // rows: power code, ir select, pin, enable
  task automatic t_lp;
    logic [7:0] r [7] = '{8'h23, 8'h25, 8'h15, 8'h75, 8'h34, 8'h73, 8'h30};
    wr(`UCG_ADDR_BAUD, 8'h01);
    wr(`UCG_ADDR_CTRL2, 8'h2b);
    wr(`UCG_ADDR_CTRL1, 8'h68);
    wr(`UCG_ADDR_CTRL1, 8'he8);
    wr(`UCG_ADDR_DATA, 8'h00);
    repeat (40) @(posedge clk);
    wr(`UCG_ADDR_POWER, 8'h01);
    rc(`UCG_ADDR_CTRL1, 8'h28);
    rc(`UCG_ADDR_CTRL2, 8'h2b);
    rc(`UCG_ADDR_BAUD, 8'h01);
    rc(`UCG_ADDR_FLAGS, 8'h00);
    `CHK({pin, oe}, 2'b11)
    for (int i = 0; i < 7; i++)
    begin
      wr(`UCG_ADDR_CTRL1, {5'h0, r[i][2], 2'h0});
      wr(`UCG_ADDR_POWER, {5'h0, r[i][6:4]});
      repeat (2) @(posedge clk);
      `CHK(oe, r[i][0])
      if (r[i][0])
        `CHK(pin, r[i][1])
    end
    wr(`UCG_ADDR_POWER, 8'h00);
    wr(`UCG_ADDR_BAUD, 8'h00);
    $display("t_lp done");
  endtask
  // reset, then each scenario in turn
  initial
  begin
    {rst_n, psel, pen, pwr, rx_act} = 5'h0;
    addr = 12'h0;
    wdat = 32'h0;
    nb = 4'd10;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_lock;
    t_frame;
    t_irq;
    t_ir;
    t_lp;
    final_report;
  end
endmodule // tb
`default_nettype wire
